/* File: hdl/p1g_regs.svh */
// register offsets, field positions and reset values of the port 1 block
`ifndef P1G_REGS_SVH
`define P1G_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define P1G_OFS_DIR      8'h00
`define P1G_OFS_DATA     8'h04
`define P1G_OFS_PULL     8'h08
`define P1G_OFS_CFG      8'h0C
`define P1G_OFS_STAT     8'h10

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define P1G_RST_BYTE     8'h00
`define P1G_RST_BIT      1'b0
`define P1G_CFG_EXP      2
`define P1G_CFG_OEA      3
`define P1G_CFG_OEB      4
`define P1G_CFG_PWM_LO   8
`define P1G_STAT_MODE_LO 0
`define P1G_STAT_PIN_LO  8
`define P1G_STAT_OE_LO   16
`define P1G_EXT_PINS     2

`endif

/* File: hdl/p1g_pkg.sv */
// types shared by the port 1 block
package p1g_pkg;

  // operating mode as strapped at reset
  typedef enum logic [1:0] {
    P1G_MODE_NONE = 2'h0,
    P1G_MODE_1    = 2'h1,
    P1G_MODE_2    = 2'h2,
    P1G_MODE_3    = 2'h3
  } p1g_mode_t;

endpackage

/* File: hdl/p1g_sync.sv */
// two-stage synchroniser for the external pin levels
`timescale 1ns/1ns
`default_nettype none

module p1g_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // asynchronous levels in, synchronous levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // first stage is seen only by the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // p1g_sync

`default_nettype wire

/* File: hdl/p1g_port.sv */
// port 1 general I/O with address, pwm and extended pwm pin sharing, wishbone slave
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "p1g_regs.svh"

module p1g_port #(
  parameter int PINS  = 8,
  parameter int ADR_W = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // operating mode strap, caught while reset is held
  input  wire logic [1:0]       mode_i,
  // alternate function sources
  input  wire logic [PINS-1:0]  addr_out_i,
  input  wire logic [PINS-1:0]  pwm_out_i,
  input  wire logic [1:0]       extended_pulse_width_output_i,
  // external pins
  input  wire logic [PINS-1:0]  pin_i,
  output logic      [PINS-1:0]  pin_o,
  output logic      [PINS-1:0]  pin_oe_o,
  output logic      [PINS-1:0]  pullup_en_o
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [PINS-1:0]  port_direction_reg_q;
  logic [PINS-1:0]  port_output_latch_q;
  logic [PINS-1:0]  port_pullup_ctrl_q;
  logic [PINS-1:0]  pwm_channel_out_en_q;
  logic             external_expansion_enable_q;
  logic             ext_pulse_out_en_a_q;
  logic             ext_pulse_out_en_b_q;
  p1g_pkg::p1g_mode_t mode_q;

  // ------------------------------------------------------------
  // pin level synchroniser
  // ------------------------------------------------------------
  logic [PINS-1:0] pin_sync;

  p1g_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire logic req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr_lo    = req & wb_we_i & wb_sel_i[0];
  wire logic wr_hi    = req & wb_we_i & wb_sel_i[1];
  wire logic hit_dir  = (wb_adr_i == ADR_W'(`P1G_OFS_DIR));
  wire logic hit_data = (wb_adr_i == ADR_W'(`P1G_OFS_DATA));
  wire logic hit_pull = (wb_adr_i == ADR_W'(`P1G_OFS_PULL));
  wire logic hit_cfg  = (wb_adr_i == ADR_W'(`P1G_OFS_CFG));
  wire logic hit_stat = (wb_adr_i == ADR_W'(`P1G_OFS_STAT));

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  // an unstrapped mode code falls back to single-chip behaviour (modes 2/3)
  wire logic mode_one = (mode_q == p1g_pkg::P1G_MODE_1);
  wire logic [1:0] ext_en = {ext_pulse_out_en_b_q, ext_pulse_out_en_a_q};

  // ------------------------------------------------------------
  // per-pin function select
  // ------------------------------------------------------------
  logic [PINS-1:0] pin_d;
  logic [PINS-1:0] oe_d;
  logic [PINS-1:0] pull_d;
  logic [PINS-1:0] port_read;

  genvar n;
  generate
    for (n = 0; n < PINS; n++) begin : g_pin
      logic ext_sel;
      logic gen_out;
      // only the two low pins can carry the extended pwm outputs
      if (n < `P1G_EXT_PINS) begin : g_ext
        assign ext_sel = ~mode_one & ext_en[n];
      end else begin : g_noext
        assign ext_sel = 1'b0;
      end
      // address when expansion is on, else the output latch
      assign gen_out = external_expansion_enable_q ? addr_out_i[n]
                                                   : port_output_latch_q[n];
      // priority: mode 1, then extended pwm, then pwm enable, then address or latch
      assign pin_d[n] = mode_one ? addr_out_i[n] :
                        ext_sel  ? extended_pulse_width_output_i[n % 2] :
                        pwm_channel_out_en_q[n] ? pwm_out_i[n] :
                        gen_out;
      assign oe_d[n]  = mode_one | ext_sel | port_direction_reg_q[n];
      // pull-up only on a true input with its control bit set
      assign pull_d[n] = ~mode_one & ~ext_sel & ~port_direction_reg_q[n]
                         & port_pullup_ctrl_q[n];
      // outputs read back their latch, inputs read the sampled level
      assign port_read[n] = port_direction_reg_q[n] ? port_output_latch_q[n]
                                                    : pin_sync[n];
    end
  endgenerate

  // ------------------------------------------------------------
  // read data mux
  // ------------------------------------------------------------
  // direction reads as zero: the register is write-only
  wire logic [31:0] cfg_rd  = {16'h0000, 8'(pwm_channel_out_en_q), 3'h0,
                               ext_pulse_out_en_b_q, ext_pulse_out_en_a_q,
                               external_expansion_enable_q, 2'h0};
  wire logic [31:0] stat_rd = {8'h00, 8'(oe_d), 8'(pin_sync), 6'h00, mode_q};
  wire logic [31:0] rd_d    = hit_data ? {24'h000000, 8'(port_read)} :
                              hit_pull ? {24'h000000, 8'(port_pullup_ctrl_q)} :
                              hit_cfg  ? cfg_rd :
                              hit_stat ? stat_rd :
                              32'h00000000;

  // ------------------------------------------------------------
  // wishbone answer: ack one cycle after the strobe, read data with it
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_d : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // mode strap, sampled every cycle while reset is held
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= p1g_pkg::p1g_mode_t'(mode_i);
    end
  end

  // ------------------------------------------------------------
  // direction, latch and pull-up registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_direction_reg_q <= PINS'(`P1G_RST_BYTE);
      port_output_latch_q  <= PINS'(`P1G_RST_BYTE);
      port_pullup_ctrl_q   <= PINS'(`P1G_RST_BYTE);
    end else begin
      if (wr_lo && hit_dir) begin
        port_direction_reg_q <= wb_dat_i[PINS-1:0];
      end
      if (wr_lo && hit_data) begin
        port_output_latch_q <= wb_dat_i[PINS-1:0];
      end
      if (wr_lo && hit_pull) begin
        port_pullup_ctrl_q <= wb_dat_i[PINS-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // alternate function enables
  // ------------------------------------------------------------
  // these bits mirror controls held by the pwm blocks in a full chip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      external_expansion_enable_q <= `P1G_RST_BIT;
      ext_pulse_out_en_a_q        <= `P1G_RST_BIT;
      ext_pulse_out_en_b_q        <= `P1G_RST_BIT;
      pwm_channel_out_en_q        <= PINS'(`P1G_RST_BYTE);
    end else begin
      if (wr_lo && hit_cfg) begin
        external_expansion_enable_q <= wb_dat_i[`P1G_CFG_EXP];
        ext_pulse_out_en_a_q        <= wb_dat_i[`P1G_CFG_OEA];
        ext_pulse_out_en_b_q        <= wb_dat_i[`P1G_CFG_OEB];
      end
      if (wr_hi && hit_cfg) begin
        pwm_channel_out_en_q <= wb_dat_i[`P1G_CFG_PWM_LO +: PINS];
      end
    end
  end

  // ------------------------------------------------------------
  // registered pin drive
  // ------------------------------------------------------------
  // one cycle of lag on the pins buys glitch-free flop outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o       <= PINS'(`P1G_RST_BYTE);
      pin_oe_o    <= PINS'(`P1G_RST_BYTE);
      pullup_en_o <= PINS'(`P1G_RST_BYTE);
    end else begin
      pin_o       <= pin_d;
      pin_oe_o    <= oe_d;
      pullup_en_o <= pull_d;
    end
  end

endmodule // p1g_port

`default_nettype wire

/* File: dv/p1g_checker.sv */
// concurrent checks on the port 1 block's bus and pin ports
`timescale 1ns/1ns
`default_nettype none

module p1g_checker #(
  parameter int PINS  = 8,
  parameter int ADR_W = 8
) (
  // ports of the watched block
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic [1:0]       mode_i,
  input wire logic [PINS-1:0]  addr_out_i,
  input wire logic [PINS-1:0]  pin_o,
  input wire logic [PINS-1:0]  pin_oe_o,
  input wire logic [PINS-1:0]  pullup_en_o
);
  // ----
  // shadow of the strap and the write-only direction bits
  // ----
  wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = tk & wb_we_i & wb_sel_i[0];
  logic [1:0]      mode_q;
  logic [PINS-1:0] dir_q;
  logic [PINS-1:0] lat_q;
  wire  [PINS-3:0] dhi = dir_q[PINS-1:2];
  // direction cannot be read back, so it is tracked from writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= mode_i;
      dir_q  <= '0;
      lat_q  <= '0;
    end else begin
      if (wr && wb_adr_i == 'h0) dir_q <= wb_dat_i[PINS-1:0];
      if (wr && wb_adr_i == 'h4) lat_q <= wb_dat_i[PINS-1:0];
    end
  end

  // ----
  // assertions
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_late: assert property (tk |=> wb_ack_o) else $error("request not acked next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  a_dir_reads_zero: assert property (tk && !wb_we_i && wb_adr_i == 'h0 |=> wb_dat_o == '0)
    else $error("direction register readable");
  a_out_pin_latch: assert property (tk && !wb_we_i && wb_adr_i == 'h4 |=>
    ((wb_dat_o[PINS-1:0] ^ $past(lat_q)) & $past(dir_q)) == '0) else $error("output pin not read from latch");
  a_mode1_addr: assert property (mode_q == 2'h1 |=> pin_oe_o == '1 && pin_o == $past(addr_out_i))
    else $error("mode 1 pin not address");
  a_mode1_no_pull: assert property (mode_q == 2'h1 |-> pullup_en_o == '0) else $error("pull-up in mode 1");
  a_pull_input: assert property ((pullup_en_o & pin_oe_o) == '0) else $error("pull-up on a driven pin");
  a_oe_from_dir: assert property (mode_q != 2'h1 && !$past(rst_i) |->
    pin_oe_o[PINS-1:2] == $past(dhi)) else $error("upper pin enable differs from direction");
  c_mode1: cover property (mode_q == 2'h1 && wb_ack_o);
  c_pull_on: cover property (pullup_en_o != '0);
  c_mixed_read: cover property (tk && wb_adr_i == 'h4 && dir_q != '0 && dir_q != '1);
endmodule // p1g_checker

bind p1g_port p1g_checker #(.PINS(PINS), .ADR_W(ADR_W)) p1g_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i, .addr_out_i, .pin_o, .pin_oe_o,
  .pullup_en_o);
`default_nettype wire

/* File: dv/p1g_pins_model.sv */
// board side of the port 1 pins: block drivers, pull-ups and outside levels
`timescale 1ns/1ns
`default_nettype none

module p1g_pins_model (
  // pin side of the block
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] pullup_en_o,
  // changing level of a floating line, so nothing stale is read
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_i
);
  // driven pin shows the block, pulled-up input reads high
  assign pin_i = (pin_o & pin_oe_o) | (~pin_oe_o & (pullup_en_o | ext_i));
endmodule // p1g_pins_model
`default_nettype wire

/* File: dv/test_p1g_port.sv */
// self-checking bench of the port 1 block against a behavioural model
`timescale 1ns/1ns
`default_nettype none

module test_p1g_port;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o;
  logic [1:0]  mode = 2'h1, xpw = 2'h0;
  logic [7:0]  adr = 8'h00, addr = 8'h00, pwm = 8'h00, ext = 8'h00;
  logic [7:0]  dir, lat, pcr, lvl, pin_i, pin_o, pin_oe_o, pullup_en_o;
  logic [31:0] wd = 32'h0, rd, cfg, wb_dat_o, seed = 32'h9272;
  logic [23:0] ex;
  int          error_cnt = 0, comparisons = 0;

  always #20 clk_i = ~clk_i;

  p1g_port p1g_port_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o, .wb_ack_o, .mode_i(mode), .addr_out_i(addr),
    .pwm_out_i(pwm), .extended_pulse_width_output_i(xpw), .pin_i, .pin_o, .pin_oe_o, .pullup_en_o);
  p1g_pins_model p1g_pins_model_i (.pin_o, .pin_oe_o, .pullup_en_o, .ext_i(ext), .pin_i);

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected {pull-up, enable, driven value} one edge after settling
  function automatic logic [23:0] exp_pins();
    logic [7:0] o, e;
    o = addr;
    e = 8'hFF;
    if (mode != 2'h1) begin
      e = dir | {6'h0, cfg[4:3]};
      o = (cfg[15:8] & pwm) | (~cfg[15:8] & (cfg[2] ? addr : lat));
      if (cfg[3]) o[0] = xpw[0];
      if (cfg[4]) o[1] = xpw[1];
      return {pcr & ~e, e, o & e};
    end
    return {8'h00, e, o};
  endfunction
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one classic cycle; ack and read data are taken at the rising edge, before the slave updates
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
    if (n >= 20) begin
      error_cnt++;
      close_out;
    end
  endtask

  // ----
  // every strap, reset values first, then random settings
  // ----
  initial begin
    for (int m = 1; m < 5; m++) begin
      mode <= m[1:0];
      rst_i <= 1'b1;
      {dir, lat, pcr, cfg} = '0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // latch reset value, seen through a data read with every pin an output
      bus(1'b1, 8'h00, 32'h000000FF);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd & 32'hFF, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      for (int k = 0; k < 7; k++) begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        ex = exp_pins();
        lvl = ex[7:0] | (~ex[15:8] & (ex[23:16] | ext));
        chk({8'h0, pullup_en_o, pin_oe_o, pin_o & pin_oe_o}, {8'h0, ex});
        bus(1'b0, 8'h04, 32'h0);
        chk(rd & 32'hFF, {24'h0, (lat & dir) | (lvl & ~dir)});
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd & 32'hFF, {24'h0, pcr});
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'hFF1C, cfg);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, {8'h00, ex[15:8], lvl, 6'h00, mode});
        bus(1'b0, 8'h24, 32'h0);
        chk(rd, 32'h0);
        if (k < 6) begin
          seed = lf(seed);
          {pcr, lat, dir} = seed[23:0];
          if (k == 4) dir = 8'hFF;
          ext <= seed[31:24];
          seed = lf(seed);
          cfg = seed & 32'hFF1C;
          {pwm, addr} <= seed[31:16];
          xpw <= seed[6:5];
          bus(1'b1, 8'h00, {24'h0, dir});
          bus(1'b1, 8'h04, {24'h0, lat});
          bus(1'b1, 8'h08, {24'h0, pcr});
          bus(1'b1, 8'h0C, cfg);
          bus(1'b1, 8'h24, seed); // unmapped, must change nothing
        end
      end
    end
    close_out;
  end
endmodule // test_p1g_port
`default_nettype wire
